// file: inc/occ_pkg.sv
// package: register map, field widths, output state codes and channel map
package occ_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int NUM_CHAN = 5;                  // channels a to e
  localparam int NUM_CLK  = 10;                 // channel clock outputs
  localparam int NUM_REF  = 8;                  // sysref capable outputs
  localparam int ADDR_W   = 8;                  // axi byte address width
  localparam int DATA_W   = 32;                 // axi data width
  localparam int STRB_W   = 4;                  // axi byte lanes
  localparam int AMP_W    = 2;                  // amplitude code width
  localparam int ST_W     = 2;                  // output state code width
  localparam int CHAN_W   = 3;                  // channel index width

  ////////////////////////////////////////////////////////////////////////////
  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CHAN_OFF  = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CLK_OFF   = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_CLK_EN    = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_CLK_AMP   = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_REF_FUNC  = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_REF_OFF   = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_REF_EN    = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_REF_BIAS  = 8'h1C;
  localparam logic [ADDR_W-1:0] ADDR_REF_AMP   = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_STATUS    = 8'h24;
  localparam logic [ADDR_W-1:0] ADDR_CLK_STATE = 8'h28;
  localparam logic [ADDR_W-1:0] ADDR_REF_STATE = 8'h2C;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [NUM_CHAN-1:0]      RST_CHAN_OFF = 5'h00;
  localparam logic [NUM_CLK-1:0]       RST_CLK_OFF  = 10'h000;
  localparam logic [NUM_CLK-1:0]       RST_CLK_EN   = 10'h000;
  localparam logic [NUM_CLK*AMP_W-1:0] RST_CLK_AMP  = 20'h00000;
  localparam logic [NUM_REF-1:0]       RST_REF_FUNC = 8'h00;
  localparam logic [NUM_REF-1:0]       RST_REF_OFF  = 8'h00;
  localparam logic [NUM_REF-1:0]       RST_REF_EN   = 8'h00;
  localparam logic [NUM_REF-1:0]       RST_REF_BIAS = 8'h00;
  localparam logic [NUM_REF*AMP_W-1:0] RST_REF_AMP  = 16'h5555;

  ////////////////////////////////////////////////////////////////////////////
  // status register fields
  localparam int STAT_ON_BIT = 8;               // sysref sequence running

  ////////////////////////////////////////////////////////////////////////////
  // output state and amplitude codes
  localparam logic [ST_W-1:0]  OUT_OFF    = 2'h0;  // powered down
  localparam logic [ST_W-1:0]  OUT_LOW    = 2'h1;  // disabled, logic low
  localparam logic [ST_W-1:0]  OUT_DRIVE  = 2'h2;  // enabled, switching
  localparam logic [ST_W-1:0]  OUT_BIAS   = 2'h3;  // line biased
  localparam logic [AMP_W-1:0] AMP_SYSREF = 2'h1;  // 500 mV code

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // channel indices
  localparam logic [CHAN_W-1:0] CH_A = 3'h0;
  localparam logic [CHAN_W-1:0] CH_B = 3'h1;
  localparam logic [CHAN_W-1:0] CH_C = 3'h2;
  localparam logic [CHAN_W-1:0] CH_D = 3'h3;
  localparam logic [CHAN_W-1:0] CH_E = 3'h4;

  // channel of a clock output: a0 a1 a2 b0 b1 c0 c1 d e0 e1
  function automatic logic [CHAN_W-1:0] clk_chan(input int idx);
    case (idx)
      0, 1, 2: clk_chan = CH_A;
      3, 4:    clk_chan = CH_B;
      5, 6:    clk_chan = CH_C;
      7:       clk_chan = CH_D;
      default: clk_chan = CH_E;
    endcase
  endfunction

  // channel of a sysref capable output: a0 a1 a2 b0 b1 c0 c1 d
  function automatic logic [CHAN_W-1:0] ref_chan(input int idx);
    case (idx)
      0, 1, 2: ref_chan = CH_A;
      3, 4:    ref_chan = CH_B;
      5, 6:    ref_chan = CH_C;
      default: ref_chan = CH_D;
    endcase
  endfunction

  // merge write data into an old word under the byte strobes
  function automatic logic [DATA_W-1:0] apply_strb(
    input logic [DATA_W-1:0] old_val,
    input logic [DATA_W-1:0] wr_val,
    input logic [STRB_W-1:0] strb
  );
    logic [DATA_W-1:0] res;
    res = old_val;
    for (int b = 0; b < STRB_W; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = wr_val[b*8 +: 8];
      end
    end
    apply_strb = res;
  endfunction

endpackage

// file: hw/occ_out_dec.sv
// module: decode of one output's settings into a registered output state
module occ_out_dec
  import occ_pkg::*;
(
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // settings
  input  wire logic                      chan_off,
  input  wire logic                      out_off,
  input  wire logic                      enable,
  input  wire logic                      line_bias,
  input  wire logic                      sysref_mode,
  input  wire logic [occ_pkg::AMP_W-1:0] amp_in,
  // sysref sequencer
  input  wire logic                      sysref_on,
  // decoded state
  output logic      [occ_pkg::ST_W-1:0]  state_r,
  output logic      [occ_pkg::AMP_W-1:0] amp_r,
  output logic                           path_r
);

  logic [ST_W-1:0] state_nxt;                 // decoded state

  ////////////////////////////////////////////////////////////////////////////
  // state decode
  always_comb begin
    if (sysref_mode) begin
      // sysref: channel power-down only, sequencer switches on and off
      if (chan_off) begin
        state_nxt = OUT_OFF;
      end else if (line_bias) begin
        state_nxt = OUT_BIAS;
      end else if (!sysref_on) begin
        state_nxt = OUT_OFF;
      end else if (!enable) begin
        state_nxt = OUT_LOW;
      end else begin
        state_nxt = OUT_DRIVE;
      end
    end else begin
      // clock: own power-down and enable
      if (chan_off || out_off) begin
        state_nxt = OUT_OFF;
      end else if (!enable) begin
        state_nxt = OUT_LOW;
      end else begin
        state_nxt = OUT_DRIVE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= OUT_OFF;
      amp_r   <= '0;
      path_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      amp_r   <= amp_in;
      path_r  <= sysref_mode;
    end
  end

endmodule

// file: hw/occ_top.sv
// module: output channel control with axi4-lite configuration registers
////////////////////////////////////////////////////////////////////////////////
//
// Implementation choices: the address map and the AXI4-Lite register port.
module occ_top
  import occ_pkg::*;
(
  // clock and reset
  input  wire logic                                CLK,
  input  wire logic                                RST_B,
  // axi4-lite write address
  input  wire logic [occ_pkg::ADDR_W-1:0]          AWADDR,
  input  wire logic                                AWVALID,
  output logic                                     AWREADY,
  // axi4-lite write data
  input  wire logic [occ_pkg::DATA_W-1:0]          WDATA,
  input  wire logic [occ_pkg::STRB_W-1:0]          WSTRB,
  input  wire logic                                WVALID,
  output logic                                     WREADY,
  // axi4-lite write response
  output logic      [1:0]                          BRESP,
  output logic                                     BVALID,
  input  wire logic                                BREADY,
  // axi4-lite read address
  input  wire logic [occ_pkg::ADDR_W-1:0]          ARADDR,
  input  wire logic                                ARVALID,
  output logic                                     ARREADY,
  // axi4-lite read data
  output logic      [occ_pkg::DATA_W-1:0]          RDATA,
  output logic      [1:0]                          RRESP,
  output logic                                     RVALID,
  input  wire logic                                RREADY,
  // sysref sequencer
  input  wire logic                                SYSREF_ON,
  // channel clock outputs
  output logic [occ_pkg::NUM_CLK*occ_pkg::ST_W-1:0]  CLK_OUT_STATE,
  output logic [occ_pkg::NUM_CLK*occ_pkg::AMP_W-1:0] CLK_OUT_AMP,
  // sysref capable outputs
  output logic [occ_pkg::NUM_REF*occ_pkg::ST_W-1:0]  REF_OUT_STATE,
  output logic [occ_pkg::NUM_REF*occ_pkg::AMP_W-1:0] REF_OUT_AMP,
  output logic [occ_pkg::NUM_REF-1:0]                REF_SYSREF_PATH
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic                      rst_s1_r;       // reset release stage one
  logic                      rst_n_r;        // released reset copy

  logic [NUM_CHAN-1:0]       chan_off_r;     // channel power-down
  logic [NUM_CLK-1:0]        clk_off_r;      // clock output power-down
  logic [NUM_CLK-1:0]        clk_en_r;       // clock output enable
  logic [NUM_CLK*AMP_W-1:0]  clk_amp_r;      // clock output amplitude
  logic [NUM_REF-1:0]        ref_func_r;     // output function select
  logic [NUM_REF-1:0]        ref_off_r;      // sysref output power-down
  logic [NUM_REF-1:0]        ref_en_r;       // sysref output enable
  logic [NUM_REF-1:0]        ref_bias_r;     // line bias control
  logic [NUM_REF*AMP_W-1:0]  ref_amp_r;      // sysref output amplitude

  logic                      awready_r;      // write address ready
  logic                      wready_r;       // write data ready
  logic                      aw_held_r;      // write address captured
  logic                      w_held_r;       // write data captured
  logic                      aw_held_nxt;
  logic                      w_held_nxt;
  logic [ADDR_W-1:0]         aw_addr_r;      // captured write address
  logic [DATA_W-1:0]         w_data_r;       // captured write data
  logic [STRB_W-1:0]         w_strb_r;       // captured byte strobes
  logic                      bvalid_r;       // write response valid
  logic [1:0]                bresp_r;        // write response code
  logic                      aw_take;        // address handshake
  logic                      w_take;         // data handshake
  logic                      do_write;       // perform register write
  logic                      wr_hit;         // write address mapped

  logic                      arready_r;      // read address ready
  logic                      rvalid_r;       // read data valid
  logic                      rvalid_nxt;
  logic [DATA_W-1:0]         rdata_r;        // read data
  logic [1:0]                rresp_r;        // read response code
  logic                      ar_take;        // read handshake
  logic [DATA_W-1:0]         rd_word;        // addressed register word
  logic                      rd_hit;         // read address mapped

  logic [NUM_REF-1:0]        amp_warn;       // sysref amplitude not 500 mV

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flip-flops: reset takes hold at once but
  // lets go on the clock, so no flop sees its release inside the setup
  // window of an edge
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write channel handshakes
  // an item moves at the edge where its valid and ready are both high
  assign aw_take  = AWVALID && awready_r;
  assign w_take   = WVALID && wready_r;
  // a waiting response holds off the next register update
  assign do_write = aw_held_r && w_held_r && !bvalid_r;

  // a held half stays until both halves are in and the write is done
  always_comb begin
    aw_held_nxt = aw_held_r || aw_take;
    w_held_nxt  = w_held_r || w_take;
    if (do_write) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
    end
  end

  // address and data capture, ready drops while a half is held
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r  <= w_held_nxt;
      // ready stays low until the response is taken: one write at a time
      awready_r <= !aw_held_nxt && !bvalid_r && !do_write;
      wready_r  <= !w_held_nxt && !bvalid_r && !do_write;
      if (aw_take) begin
        aw_addr_r <= AWADDR;
      end
      if (w_take) begin
        w_data_r <= WDATA;
        w_strb_r <= WSTRB;
      end
    end
  end

  // writable addresses
  // status and state words are read-only and answer with slverr
  always_comb begin
    case (aw_addr_r)
      ADDR_CHAN_OFF, ADDR_CLK_OFF, ADDR_CLK_EN, ADDR_CLK_AMP,
      ADDR_REF_FUNC, ADDR_REF_OFF, ADDR_REF_EN, ADDR_REF_BIAS,
      ADDR_REF_AMP: wr_hit = 1'b1;
      default:      wr_hit = 1'b0;
    endcase
  end

  // write response, held until the master takes it
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (do_write) begin
      // raised as the register lands, code chosen by the address
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_r && BREADY) begin
      // dropped at the edge the master takes it
      bvalid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers, applied to the decode with no handshake
  // a new value reaches the decode one edge after the write and the
  // outputs one edge after that; bits above a field's width are dropped
  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      chan_off_r <= RST_CHAN_OFF;
      clk_off_r  <= RST_CLK_OFF;
      clk_en_r   <= RST_CLK_EN;
      clk_amp_r  <= RST_CLK_AMP;
      ref_func_r <= RST_REF_FUNC;
      ref_off_r  <= RST_REF_OFF;
      ref_en_r   <= RST_REF_EN;
      ref_bias_r <= RST_REF_BIAS;
      ref_amp_r  <= RST_REF_AMP;
    end else if (do_write) begin
      case (aw_addr_r)
        // per channel power-down
        ADDR_CHAN_OFF: chan_off_r <= NUM_CHAN'(
            apply_strb(DATA_W'(chan_off_r), w_data_r, w_strb_r));
        // per clock output power-down
        ADDR_CLK_OFF: clk_off_r <= NUM_CLK'(
            apply_strb(DATA_W'(clk_off_r), w_data_r, w_strb_r));
        // per clock output enable
        ADDR_CLK_EN: clk_en_r <= NUM_CLK'(
            apply_strb(DATA_W'(clk_en_r), w_data_r, w_strb_r));
        // per clock output amplitude
        ADDR_CLK_AMP: clk_amp_r <= (NUM_CLK*AMP_W)'(
            apply_strb(DATA_W'(clk_amp_r), w_data_r, w_strb_r));
        // sysref or clock function of each sysref capable output
        ADDR_REF_FUNC: ref_func_r <= NUM_REF'(
            apply_strb(DATA_W'(ref_func_r), w_data_r, w_strb_r));
        // clock-mode power-down of sysref capable outputs
        ADDR_REF_OFF: ref_off_r <= NUM_REF'(
            apply_strb(DATA_W'(ref_off_r), w_data_r, w_strb_r));
        // sysref capable output enable
        ADDR_REF_EN: ref_en_r <= NUM_REF'(
            apply_strb(DATA_W'(ref_en_r), w_data_r, w_strb_r));
        // line bias of sysref outputs
        ADDR_REF_BIAS: ref_bias_r <= NUM_REF'(
            apply_strb(DATA_W'(ref_bias_r), w_data_r, w_strb_r));
        // sysref capable output amplitude
        ADDR_REF_AMP: ref_amp_r <= (NUM_REF*AMP_W)'(
            apply_strb(DATA_W'(ref_amp_r), w_data_r, w_strb_r));
        // unmapped or read-only: nothing stored
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sysref outputs whose amplitude is not the required 500 mV code
  // the code is not forced: software reads this flag and mends it
  always_comb begin
    for (int i = 0; i < NUM_REF; i++) begin
      amp_warn[i] = ref_func_r[i] &&
                    (ref_amp_r[i*AMP_W +: AMP_W] != AMP_SYSREF);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read word mux
  // decoded straight from the bus address, which stands while arvalid waits
  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    case (ARADDR)
      ADDR_CHAN_OFF:  rd_word[NUM_CHAN-1:0]      = chan_off_r;
      ADDR_CLK_OFF:   rd_word[NUM_CLK-1:0]       = clk_off_r;
      ADDR_CLK_EN:    rd_word[NUM_CLK-1:0]       = clk_en_r;
      ADDR_CLK_AMP:   rd_word[NUM_CLK*AMP_W-1:0] = clk_amp_r;
      ADDR_REF_FUNC:  rd_word[NUM_REF-1:0]       = ref_func_r;
      ADDR_REF_OFF:   rd_word[NUM_REF-1:0]       = ref_off_r;
      ADDR_REF_EN:    rd_word[NUM_REF-1:0]       = ref_en_r;
      ADDR_REF_BIAS:  rd_word[NUM_REF-1:0]       = ref_bias_r;
      ADDR_REF_AMP:   rd_word[NUM_REF*AMP_W-1:0] = ref_amp_r;
      // amplitude warnings and sequencer activity
      ADDR_STATUS: begin
        rd_word[NUM_REF-1:0] = amp_warn;
        rd_word[STAT_ON_BIT] = SYSREF_ON;
      end
      // decoded output states as driven
      ADDR_CLK_STATE: rd_word[NUM_CLK*ST_W-1:0] = CLK_OUT_STATE;
      ADDR_REF_STATE: rd_word[NUM_REF*ST_W-1:0] = REF_OUT_STATE;
      default:        rd_hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel: one read under way, data held until taken
  // arready stays low while data waits; rdata loads only on a handshake
  assign ar_take    = ARVALID && arready_r;
  assign rvalid_nxt = ar_take || (rvalid_r && !RREADY);

  always_ff @(posedge CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
    end else begin
      arready_r <= !rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (ar_take) begin
        rdata_r <= rd_word;
        rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus outputs straight from flip-flops
  assign AWREADY = awready_r;
  assign WREADY  = wready_r;
  assign BVALID  = bvalid_r;
  assign BRESP   = bresp_r;
  assign ARREADY = arready_r;
  assign RVALID  = rvalid_r;
  assign RDATA   = rdata_r;
  assign RRESP   = rresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // channel clock outputs: always clock mode, no line bias
  // power-down and enable of each output come from the clock registers
  for (genvar i = 0; i < NUM_CLK; i++) begin : g_clk
    occ_out_dec u_dec (
      .clk         (CLK),
      .rst_n       (rst_n_r),
      .chan_off    (chan_off_r[clk_chan(i)]),
      .out_off     (clk_off_r[i]),
      .enable      (clk_en_r[i]),
      .line_bias   (1'b0),
      .sysref_mode (1'b0),
      .amp_in      (clk_amp_r[i*AMP_W +: AMP_W]),
      .sysref_on   (SYSREF_ON),
      .state_r     (CLK_OUT_STATE[i*ST_W +: ST_W]),
      .amp_r       (CLK_OUT_AMP[i*AMP_W +: AMP_W]),
      .path_r      ()
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // sysref capable outputs on channels a to d only
  // in sysref mode only the channel power-down counts, and the sequencer
  // decides when an enabled output drives
  for (genvar i = 0; i < NUM_REF; i++) begin : g_ref
    occ_out_dec u_dec (
      .clk         (CLK),
      .rst_n       (rst_n_r),
      .chan_off    (chan_off_r[ref_chan(i)]),
      .out_off     (ref_off_r[i]),
      .enable      (ref_en_r[i]),
      .line_bias   (ref_bias_r[i]),
      .sysref_mode (ref_func_r[i]),
      .amp_in      (ref_amp_r[i*AMP_W +: AMP_W]),
      .sysref_on   (SYSREF_ON),
      .state_r     (REF_OUT_STATE[i*ST_W +: ST_W]),
      .amp_r       (REF_OUT_AMP[i*AMP_W +: AMP_W]),
      .path_r      (REF_SYSREF_PATH[i])
    );
  end

endmodule

// file: testbench/occ_props.sv
// checker: bus handshake and output decode properties of occ_top
module occ_props
  import occ_pkg::*;
(
  // clock, reset and bus handshakes
  input wire logic CLK, RST_B, AWVALID, AWREADY, WVALID, WREADY,
  input wire logic BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY,
  input wire logic [1:0] BRESP,
  input wire logic [occ_pkg::DATA_W-1:0] RDATA,
  // sequencer and decoded outputs
  input wire logic SYSREF_ON,
  input wire logic [occ_pkg::NUM_CLK*occ_pkg::ST_W-1:0] CLK_OUT_STATE,
  input wire logic [occ_pkg::NUM_REF*occ_pkg::ST_W-1:0] REF_OUT_STATE,
  input wire logic [occ_pkg::NUM_REF-1:0] REF_SYSREF_PATH
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  ////////////////////////////////////////////////////////////////////////////
  // register bus
  ar_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read not answered");
  r_hold_a: assert property (RVALID && !RREADY
    |=> RVALID && $stable(RDATA))
    else $error("read data dropped");
  b_hold_a: assert property (BVALID && !BREADY
    |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  ar_block_a: assert property (RVALID |-> !ARREADY)
    else $error("address taken during read");
  aw_block_a: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken during response");
  wr_answer_a: assert property (AWVALID && AWREADY && WVALID && WREADY
    |-> ##[1:2] BVALID)
    else $error("write not answered");
  ////////////////////////////////////////////////////////////////////////////
  // decode: clock outputs never line biased
  clk_nobias_a: assert property ((CLK_OUT_STATE
    & (CLK_OUT_STATE >> 1) & 20'h55555) == 20'h00000)
    else $error("clock output biased");
  // sysref outputs only drive while the sequencer runs
  for (genvar i = 0; i < NUM_REF; i++) begin : g_ref
    ref_idle_a: assert property (REF_SYSREF_PATH[i] && !$past(SYSREF_ON)
      |-> REF_OUT_STATE[2*i +: 2] != OUT_DRIVE)
      else $error("sysref output driven while idle");
  end
  cover property (BVALID && BRESP == RESP_SLVERR);
  cover property (REF_OUT_STATE[1:0] == OUT_BIAS);
  cover property (REF_SYSREF_PATH[1] && REF_OUT_STATE[3:2] == OUT_DRIVE);
endmodule
bind occ_top occ_props u_occ_props (.*);

// file: testbench/tb_occ_top.sv
// testbench: register access and output decode of occ_top
module tb_occ_top
  import occ_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 1'h0, RST_B = 1'h0, SYSREF_ON = 1'h0, AWVALID = 1'h0;
  logic WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [ADDR_W-1:0] AWADDR = 8'h00, ARADDR = 8'h00;
  logic [DATA_W-1:0] WDATA = 32'h0, RDATA;
  logic [STRB_W-1:0] WSTRB = 4'hF;
  logic [1:0] BRESP, RRESP;
  logic [19:0] CLK_OUT_STATE, CLK_OUT_AMP;
  logic [15:0] REF_OUT_STATE, REF_OUT_AMP;
  logic [7:0] REF_SYSREF_PATH;
  logic [33:0] qr[$];  // expected read {resp, data}
  logic [1:0] qb[$];   // expected write responses
  int errors = 0, checked = 0;
  logic [31:0] a, o, e, f;
  // clock outputs of each channel a..e
  localparam logic [9:0] CM [5] = '{10'h007, 10'h018, 10'h060, 10'h080,
    10'h300};
  occ_top u_occ_top (.*);
  always #25 CLK = ~CLK;
  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(string n, logic [33:0] x, logic [33:0] g);
    checked++;
    if (x !== g) begin
      errors++;
      $display("wrong value %s exp %h got %h", n, x, g);
    end
  endtask
  // axi write: note the response, hold each channel until taken
  task automatic wr(logic [7:0] ad, logic [31:0] d, logic [1:0] r = RESP_OKAY);
    @(posedge CLK);
    qb.push_back(r);
    AWADDR <= ad; WDATA <= d; AWVALID <= 1'h1; WVALID <= 1'h1; BREADY <= 1'h1;
    do begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 1'h0;
      if (WREADY) WVALID <= 1'h0;
    end while (!BVALID);
    BREADY <= 1'h0;
  endtask
  // axi read: note expected {resp, data}
  task automatic rd(logic [7:0] ad, logic [33:0] x);
    @(posedge CLK);
    qr.push_back(x);
    ARADDR <= ad; ARVALID <= 1'h1; RREADY <= 1'h1;
    do begin
      @(posedge CLK);
      if (ARREADY) ARVALID <= 1'h0;
    end while (!RVALID);
    RREADY <= 1'h0;
  endtask
  // let the register write and the decode edge land
  task automatic settle();
    repeat (2) @(posedge CLK);
    #1;
  endtask
  // expected state codes: f sysref mode, o off, e enable, b line bias
  function automatic logic [19:0] ex(logic [9:0] f, o, e, b, logic on);
    for (int i = 0; i < 10; i++) begin
      ex[2*i +: 2] = o[i] ? OUT_OFF : (f[i] && b[i]) ? OUT_BIAS :
        (f[i] && !on) ? OUT_OFF : e[i] ? OUT_DRIVE : OUT_LOW;
    end
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watcher: oldest note against each bus answer
  always @(posedge CLK) begin
    if (RVALID && RREADY) cmp("read", qr.pop_front(), {RRESP, RDATA});
    if (BVALID && BREADY) cmp("bresp", qb.pop_front(), BRESP);
  end
  initial begin
    repeat (20000) @(posedge CLK);
    errors++;
    end_of_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(57681));
    repeat (3) @(posedge CLK);
    RST_B <= 1'h1;
    repeat (4) @(posedge CLK);
    rd(ADDR_REF_AMP, {18'h0, RST_REF_AMP});
    rd(8'h30, {RESP_SLVERR, 32'h0});
    wr(8'h30, 32'h1, RESP_SLVERR);
    wr(ADDR_STATUS, 32'h1, RESP_SLVERR);
    settle();
    cmp("ref amp", RST_REF_AMP, REF_OUT_AMP);
    $display("test reset done");
    // random clock settings, one channel powered down each pass
    for (int k = 0; k < 5; k++) begin
      a = $urandom; o = $urandom; e = $urandom;
      wr(ADDR_CLK_AMP, a);
      wr(ADDR_CLK_OFF, o);
      wr(ADDR_CLK_EN, e);
      wr(ADDR_CHAN_OFF, 32'h1 << k);
      settle();
      cmp("clk state", ex(0, o[9:0] | CM[k], e[9:0], 0, 0),
        CLK_OUT_STATE);
    end
    wr(ADDR_CHAN_OFF, 32'h0);
    wr(ADDR_CLK_OFF, 32'h0);
    wr(ADDR_CLK_EN, 32'h3FF);
    settle();
    cmp("clk amp", a[19:0], CLK_OUT_AMP);
    $display("test clock outputs done");
    // sysref mode mix with channel b down and sequencer toggling
    wr(ADDR_REF_OFF, 32'h5A);
    wr(ADDR_REF_EN, 32'h0F);
    wr(ADDR_REF_BIAS, 32'h01);
    wr(ADDR_REF_AMP, 32'h5554);
    wr(ADDR_CHAN_OFF, 32'h2);
    for (int k = 0; k < 6; k++) begin
      f = $urandom;
      @(posedge CLK);
      SYSREF_ON <= k[0];
      wr(ADDR_REF_FUNC, f);
      settle();
      cmp("ref state", ex({2'h0, f[7:0]}, {2'h3, 8'h18 | (~f[7:0] & 8'h5A)},
        10'h0F, 10'h01, k[0]), REF_OUT_STATE);
      cmp("ref path", f[7:0], REF_SYSREF_PATH);
      rd(ADDR_STATUS, {25'h0, k[0], 7'h0, f[0]});
    end
    $display("test sysref outputs done");
    repeat (4) @(posedge CLK);
    end_of_test();
  end
endmodule
